//--- shared/rfsp_consts.svh
// Offsets, pointer register indices, reset values, step sizes and counts for the register file and stack pointer
`ifndef RFSP_CONSTS_SVH
`define RFSP_CONSTS_SVH
`define RFSP_NUM_REGS 32
`define RFSP_REG_TOP 16'h001F
`define RFSP_IO_TO_DATA 16'h0020
`define RFSP_IO_SIZE 16'h0040
`define RFSP_SP_LO_ADDR 16'h005D
`define RFSP_SP_HI_ADDR 16'h005E
`define RFSP_SP_LO_IO 6'h3D
`define RFSP_TEMP_ADDR 16'h005C
`define RFSP_SP_RESET 16'h10FF
`define RFSP_PTR_BASE 5'h1A
`define RFSP_PTR_Z_SEL 2'h2
`define RFSP_STEP1 16'h0001
`define RFSP_STEP2 16'h0002
`endif

//--- shared/rfsp_pkg.sv
// Types shared by the register file and stack pointer block
package rfsp_pkg;
	// Stack pointer adjustment requested by the executing instruction
	typedef enum logic [2:0] {
		STK_NONE,
		STK_PUSH,
		STK_POP,
		STK_CALL,
		STK_RET
	} rfsp_stk_e;
	// Pointer update applied during an indirect access
	typedef enum logic [1:0] {
		PTR_PLAIN,
		PTR_POSTINC,
		PTR_PREDEC,
		PTR_DISP
	} rfsp_ptr_e;
endpackage : rfsp_pkg

//--- verilog/rfsp_regfile.sv
// Working register file, index pointers, stack pointer and temporary byte for 16-bit access
`timescale 1ns/1ps
`include "rfsp_consts.svh"
module rfsp_regfile #(
	parameter int PTR_W = 16 // Pointer and data address width
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Operand read ports, data one cycle after address
	input wire logic [4:0] rd_a_addr,
	input wire logic [4:0] rd_b_addr,
	output logic [7:0] rd_a_data_r,
	output logic [7:0] rd_b_data_r,
	output logic [15:0] rd_w_data_r,
	// Result write ports
	input wire logic wr_en,
	input wire logic [4:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic wr16_en,
	input wire logic [15:0] wr16_data,
	// Indirect addressing through a pointer pair
	input wire logic ptr_go,
	input wire logic [1:0] ptr_sel,
	input wire rfsp_pkg::rfsp_ptr_e ptr_mode,
	input wire logic [5:0] ptr_disp,
	output logic [15:0] ptr_addr_r,
	// Data space and port accesses
	input wire logic acc_en,
	input wire logic io_en,
	input wire logic acc_we,
	input wire logic [15:0] acc_addr,
	input wire logic [5:0] io_addr,
	input wire logic [7:0] acc_wdata,
	output logic [7:0] acc_rdata_r,
	output logic acc_hit_r,
	// Stack adjustment
	input wire rfsp_pkg::rfsp_stk_e stk_op,
	output logic [15:0] stack_top_pointer_r
);

	// Elaboration check: the pointer logic is built for 16-bit addresses
	if (PTR_W != 16) begin : g_bad_width
		$error("rfsp_regfile supports PTR_W of 16 only");
	end

	// Register state
	logic [7:0] regs_r [`RFSP_NUM_REGS]; // Working registers
	logic [7:0] regs_nxt [`RFSP_NUM_REGS];
	logic [15:0] sp_r; // Stack pointer
	logic [15:0] sp_nxt;
	logic [7:0] temp_r; // Shared temporary byte for 16-bit access
	logic [7:0] temp_nxt;
	logic [7:0] rd_a_nxt;
	logic [7:0] rd_b_nxt;
	logic [15:0] rd_w_nxt;
	logic [7:0] rdata_nxt;
	logic hit_nxt;
	logic [15:0] ptr_addr_nxt;
	// Pointer arithmetic and access decode
	logic [15:0] ptr_base; // Current pointer value
	logic [15:0] ptr_ea; // Address actually used
	logic [15:0] ptr_new; // Value written back into the pair
	logic [15:0] eff_addr; // Address of this cycle's access
	logic acc_any; // Any access this cycle
	logic sp_lo_wr; // Helpers read by the checks below
	logic sp_hi_wr;
	logic sp_lo_rd;

	// Index of the low register of a pointer pair; code 3 aliases the last pair
	function automatic logic [4:0] ptr_lo_idx(input logic [1:0] sel);
		logic [1:0] s;
		s = (sel > `RFSP_PTR_Z_SEL) ? `RFSP_PTR_Z_SEL : sel;
		ptr_lo_idx = `RFSP_PTR_BASE + {2'b00, s, 1'b0};
	endfunction : ptr_lo_idx

	// Even register index of a 16-bit pair
	function automatic logic [4:0] pair_lo(input logic [4:0] idx);
		pair_lo = {idx[4:1], 1'b0};
	endfunction : pair_lo

	// Pointer value and displacement or auto-update
	always_comb begin
		ptr_base = {regs_r[ptr_lo_idx(ptr_sel) + 5'd1], regs_r[ptr_lo_idx(ptr_sel)]};
		ptr_ea = ptr_base;
		ptr_new = ptr_base;
		case (ptr_mode)
			rfsp_pkg::PTR_POSTINC: begin
				ptr_new = ptr_base + `RFSP_STEP1;
			end
			rfsp_pkg::PTR_PREDEC: begin
				ptr_ea = ptr_base - `RFSP_STEP1;
				ptr_new = ptr_ea;
			end
			rfsp_pkg::PTR_DISP: begin
				ptr_ea = ptr_base + {10'h000, ptr_disp};
			end
			default: begin
				ptr_ea = ptr_base;
			end
		endcase
	end

	// Access address: indirect wins, then port space, then direct data space
	always_comb begin
		acc_any = ptr_go | io_en | acc_en;
		if (ptr_go) begin
			eff_addr = ptr_ea;
		end else if (io_en) begin
			eff_addr = {10'h000, io_addr} + `RFSP_IO_TO_DATA;
		end else begin
			eff_addr = acc_addr;
		end
		sp_lo_wr = acc_any & acc_we & (eff_addr == `RFSP_SP_LO_ADDR);
		sp_hi_wr = acc_any & acc_we & (eff_addr == `RFSP_SP_HI_ADDR);
		sp_lo_rd = acc_any & ~acc_we & (eff_addr == `RFSP_SP_LO_ADDR);
	end

	// Next state of registers, stack pointer, temp byte and read data
	always_comb begin
		regs_nxt = regs_r;
		sp_nxt = sp_r;
		temp_nxt = temp_r;
		rdata_nxt = 8'h00;
		hit_nxt = 1'b0;
		ptr_addr_nxt = ptr_addr_r;
		// Stack adjustment; downward growth keeps the pointer at the top
		case (stk_op)
			rfsp_pkg::STK_PUSH: sp_nxt = sp_r - `RFSP_STEP1;
			rfsp_pkg::STK_POP: sp_nxt = sp_r + `RFSP_STEP1;
			rfsp_pkg::STK_CALL: sp_nxt = sp_r - `RFSP_STEP2;
			rfsp_pkg::STK_RET: sp_nxt = sp_r + `RFSP_STEP2;
			default: sp_nxt = sp_r;
		endcase
		// Result inputs, 8-bit or 16-bit pair
		if (wr_en) begin
			regs_nxt[wr_addr] = wr_data;
		end
		if (wr16_en) begin
			regs_nxt[pair_lo(wr_addr)] = wr16_data[7:0];
			regs_nxt[pair_lo(wr_addr) + 5'd1] = wr16_data[15:8];
		end
		// Pointer write-back of the auto-updated value
		if (ptr_go) begin
			regs_nxt[ptr_lo_idx(ptr_sel)] = ptr_new[7:0];
			regs_nxt[ptr_lo_idx(ptr_sel) + 5'd1] = ptr_new[15:8];
			ptr_addr_nxt = ptr_ea;
		end
		// Bus access; applied last so software writes win over same-cycle updates
		if (acc_any) begin
			hit_nxt = 1'b1;
			if (eff_addr <= `RFSP_REG_TOP) begin
				// Registers alias the bottom of data space
				if (acc_we) begin
					regs_nxt[eff_addr[4:0]] = acc_wdata;
				end else begin
					rdata_nxt = regs_r[eff_addr[4:0]];
				end
			end else if (eff_addr == `RFSP_SP_LO_ADDR) begin
				// Low byte goes only to temp; low read latches the high byte
				if (acc_we) begin
					temp_nxt = acc_wdata;
				end else begin
					rdata_nxt = sp_r[7:0];
					temp_nxt = sp_r[15:8];
				end
			end else if (eff_addr == `RFSP_SP_HI_ADDR) begin
				// High write commits both bytes in one edge
				if (acc_we) begin
					sp_nxt = {acc_wdata, temp_r};
				end else begin
					rdata_nxt = temp_r;
				end
			end else if (eff_addr == `RFSP_TEMP_ADDR) begin
				// Direct temp access; an interrupt handler touching it breaks a pair in flight
				if (acc_we) begin
					temp_nxt = acc_wdata;
				end else begin
					rdata_nxt = temp_r;
				end
			end else begin
				hit_nxt = 1'b0; // Unmapped here, reads as zero
			end
		end
		// Registered operands see this cycle's writes, so no stale read follows a write
		rd_a_nxt = regs_nxt[rd_a_addr];
		rd_b_nxt = regs_nxt[rd_b_addr];
		rd_w_nxt = {regs_nxt[pair_lo(rd_a_addr) + 5'd1], regs_nxt[pair_lo(rd_a_addr)]};
	end

	// State registers
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			regs_r <= '{default: 8'h00};
			sp_r <= `RFSP_SP_RESET;
			temp_r <= 8'h00;
			rd_a_data_r <= 8'h00;
			rd_b_data_r <= 8'h00;
			rd_w_data_r <= 16'h0000;
			acc_rdata_r <= 8'h00;
			acc_hit_r <= 1'b0;
			ptr_addr_r <= 16'h0000;
			stack_top_pointer_r <= `RFSP_SP_RESET;
		end else begin
			regs_r <= regs_nxt;
			sp_r <= sp_nxt;
			temp_r <= temp_nxt;
			rd_a_data_r <= rd_a_nxt;
			rd_b_data_r <= rd_b_nxt;
			rd_w_data_r <= rd_w_nxt;
			acc_rdata_r <= rdata_nxt;
			acc_hit_r <= hit_nxt;
			ptr_addr_r <= ptr_addr_nxt;
			stack_top_pointer_r <= sp_nxt;
		end
	end

	// Checks; all on the one clock and quiet while reset is held
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	// Reset value must already stand at the first edge after release
	chk_sp_reset_val: assert property ($fell(reset) |-> sp_r == `RFSP_SP_RESET)
		else $error("stack pointer not at reset value after reset");
	// Stack moves; a same-cycle high-byte bus write takes precedence, so those cycles are left out
	chk_push_pop_one: assert property (
		(stk_op == rfsp_pkg::STK_PUSH || stk_op == rfsp_pkg::STK_POP) && !sp_hi_wr
		|=> sp_r == $past(sp_r) + (($past(stk_op) == rfsp_pkg::STK_POP) ? `RFSP_STEP1 : -`RFSP_STEP1))
		else $error("byte push or pop moved stack pointer wrongly");
	chk_call_down_two: assert property (stk_op == rfsp_pkg::STK_CALL && !sp_hi_wr
		|=> sp_r == $past(sp_r) - `RFSP_STEP2)
		else $error("call did not lower stack pointer by two");
	chk_ret_up_two: assert property (stk_op == rfsp_pkg::STK_RET && !sp_hi_wr
		|=> sp_r == $past(sp_r) + `RFSP_STEP2)
		else $error("return did not raise stack pointer by two");
	// Two-byte stack pointer access through the temporary byte
	// The low half never reaches the pointer on its own, so a lone low write is harmless
	chk_low_write_held: assert property (sp_lo_wr && stk_op == rfsp_pkg::STK_NONE
		|=> sp_r == $past(sp_r) && temp_r == $past(acc_wdata))
		else $error("low byte write reached the stack pointer directly");
	chk_high_write_pair: assert property (sp_hi_wr |=> sp_r == {$past(acc_wdata), $past(temp_r)})
		else $error("high byte write did not commit both bytes");
	chk_low_read_latch: assert property (sp_lo_rd
		|=> temp_r == $past(sp_r[15:8]) && acc_rdata_r == $past(sp_r[7:0]))
		else $error("low byte read did not latch high byte");
	chk_high_read_temp: assert property (acc_any && !acc_we && eff_addr == `RFSP_SP_HI_ADDR
		|=> acc_rdata_r == $past(temp_r))
		else $error("high byte read did not return the temporary byte");
	// Direct temp access; a handler that touches it in the middle of a pair spoils that pair
	chk_temp_write: assert property (acc_any && acc_we && eff_addr == `RFSP_TEMP_ADDR
		|=> temp_r == $past(acc_wdata))
		else $error("direct write missed the temporary byte");
	chk_temp_read: assert property (acc_any && !acc_we && eff_addr == `RFSP_TEMP_ADDR
		|=> acc_rdata_r == $past(temp_r) ##0 acc_hit_r)
		else $error("direct read did not return the temporary byte");
	// Addresses outside this block must stay silent, so a neighbour can answer them
	chk_unmapped_quiet: assert property (
		acc_any && eff_addr > `RFSP_REG_TOP && eff_addr != `RFSP_TEMP_ADDR
		&& eff_addr != `RFSP_SP_LO_ADDR && eff_addr != `RFSP_SP_HI_ADDR
		|=> !acc_hit_r && acc_rdata_r == 8'h00)
		else $error("unmapped access answered");
	// Working registers seen from data space and through the pointers
	chk_reg_alias_wr: assert property (
		acc_en && !io_en && !ptr_go && acc_we && acc_addr <= `RFSP_REG_TOP
		|=> acc_hit_r ##0 regs_r[$past(acc_addr[4:0])] == $past(acc_wdata))
		else $error("data space write missed its working register");
	chk_ptr_postinc: assert property (
		ptr_go && ptr_mode == rfsp_pkg::PTR_POSTINC && !acc_we && !wr_en && !wr16_en
		|=> ptr_addr_r == $past(ptr_base)
		##0 {regs_r[ptr_lo_idx($past(ptr_sel)) + 5'd1], regs_r[ptr_lo_idx($past(ptr_sel))]}
		== $past(ptr_base) + `RFSP_STEP1)
		else $error("post-increment access wrong");
	chk_ptr_predec: assert property (
		ptr_go && ptr_mode == rfsp_pkg::PTR_PREDEC && !acc_we && !wr_en && !wr16_en
		|=> ptr_addr_r == $past(ptr_base) - `RFSP_STEP1
		##0 {regs_r[ptr_lo_idx($past(ptr_sel)) + 5'd1], regs_r[ptr_lo_idx($past(ptr_sel))]} == ptr_addr_r)
		else $error("pre-decrement access wrong");
	// Results must be visible to the very next operand read; later writes to the same cycle are left out
	chk_alu_write_seen: assert property (wr_en && !wr16_en && !ptr_go && !(acc_any && acc_we)
		##1 rd_a_addr == $past(wr_addr) && !wr_en && !wr16_en && !ptr_go && !(acc_any && acc_we)
		|=> rd_a_data_r == $past(wr_data, 2))
		else $error("following read missed the result write");
	// Scenario covers

	cov_push: cover property (stk_op == rfsp_pkg::STK_PUSH ##1 stk_op == rfsp_pkg::STK_POP);
	cov_pair_write: cover property (sp_lo_wr ##[1:4] sp_hi_wr);
	cov_pair_read: cover property (sp_lo_rd ##[1:4] (acc_any && !acc_we && eff_addr == `RFSP_SP_HI_ADDR));
	cov_postinc: cover property (ptr_go && ptr_mode == rfsp_pkg::PTR_POSTINC);
	cov_wide_write: cover property (wr16_en);

endmodule : rfsp_regfile

//--- verification/rfsp_cpu_model.sv
// Execution-side model issuing data-space, port and indirect byte accesses
`timescale 1ns/1ps
module rfsp_cpu_model (
	// Clock
	input wire logic sys_clk,
	// Request
	output logic acc_en,
	output logic io_en,
	output logic ptr_go,
	output logic acc_we,
	output logic [15:0] acc_addr,
	output logic [5:0] io_addr,
	output logic [7:0] acc_wdata,
	output logic [1:0] ptr_sel,
	output rfsp_pkg::rfsp_ptr_e ptr_mode,
	output logic [5:0] ptr_disp,
	// Answer
	input wire logic [7:0] acc_rdata_r,
	input wire logic acc_hit_r
);
	// Idle bus at time zero
	initial begin
		{acc_en, io_en, ptr_go, acc_we, acc_addr, io_addr, acc_wdata, ptr_sel, ptr_disp} = '0;
		ptr_mode = rfsp_pkg::PTR_PLAIN;
	end
	// One byte access, k 0 data, 1 port, 2 indirect; callers go low byte first
	task automatic xfer(input int k, input logic we, input logic [15:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic h);
		@(posedge sys_clk) #1;
		acc_en = (k == 0);
		io_en = (k == 1);
		ptr_go = (k == 2);
		acc_we = we;
		acc_addr = a;
		io_addr = a[5:0];
		ptr_sel = a[1:0];
		ptr_mode = rfsp_pkg::rfsp_ptr_e'(a[3:2]);
		ptr_disp = a[9:4];
		acc_wdata = d;
		@(posedge sys_clk) #1;
		q = acc_rdata_r;
		h = acc_hit_r;
		{acc_en, io_en, ptr_go, acc_we} = 4'h0;
		// Released address and write data lines must not keep their last value
		acc_addr = ~acc_addr;
		acc_wdata = ~acc_wdata;
	endtask : xfer
endmodule : rfsp_cpu_model

//--- verification/tb_rfsp_regfile.sv
// Self-checking bench for the register file and stack pointer
`timescale 1ns/1ps
module tb_rfsp_regfile;
	logic sys_clk, reset, wr_en, wr16_en, acc_en, io_en, ptr_go, acc_we, acc_hit_r, h;
	logic [4:0] rd_a_addr, rd_b_addr, wr_addr;
	logic [7:0] wr_data, rd_a_data_r, rd_b_data_r, acc_rdata_r, acc_wdata, q;
	logic [15:0] wr16_data, rd_w_data_r, ptr_addr_r, acc_addr, stack_top_pointer_r;
	logic [5:0] ptr_disp, io_addr;
	logic [1:0] ptr_sel;
	rfsp_pkg::rfsp_ptr_e ptr_mode;
	rfsp_pkg::rfsp_stk_e stk_op;
	int bad_count, compares;
	rfsp_regfile dut (
		.sys_clk(sys_clk),
		.reset(reset),
		.rd_a_addr(rd_a_addr),
		.rd_b_addr(rd_b_addr),
		.rd_a_data_r(rd_a_data_r),
		.rd_b_data_r(rd_b_data_r),
		.rd_w_data_r(rd_w_data_r),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr16_en(wr16_en),
		.wr16_data(wr16_data),
		.ptr_go(ptr_go),
		.ptr_sel(ptr_sel),
		.ptr_mode(ptr_mode),
		.ptr_disp(ptr_disp),
		.ptr_addr_r(ptr_addr_r),
		.acc_en(acc_en),
		.io_en(io_en),
		.acc_we(acc_we),
		.acc_addr(acc_addr),
		.io_addr(io_addr),
		.acc_wdata(acc_wdata),
		.acc_rdata_r(acc_rdata_r),
		.acc_hit_r(acc_hit_r),
		.stk_op(stk_op),
		.stack_top_pointer_r(stack_top_pointer_r)
	);
	rfsp_cpu_model cpu (
		.sys_clk(sys_clk),
		.acc_en(acc_en),
		.io_en(io_en),
		.ptr_go(ptr_go),
		.acc_we(acc_we),
		.acc_addr(acc_addr),
		.io_addr(io_addr),
		.acc_wdata(acc_wdata),
		.ptr_sel(ptr_sel),
		.ptr_mode(ptr_mode),
		.ptr_disp(ptr_disp),
		.acc_rdata_r(acc_rdata_r),
		.acc_hit_r(acc_hit_r)
	);
	// 125 MHz clock
	initial begin
		sys_clk = 0;
		forever #4 sys_clk = ~sys_clk;
	end
	task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("Error t=%0t got %h exp %h", $time, g, e);
		end
	endtask : cmp8
	task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("Error t=%0t got %h exp %h", $time, g, e);
		end
	endtask : cmp16
	task automatic results;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results
	task automatic tick;
		@(posedge sys_clk) #1;
	endtask : tick
	// Pair write through the 16-bit result port
	task automatic w16(input logic [4:0] a, input logic [15:0] d);
		tick;
		wr16_en = 1;
		wr_addr = a;
		wr16_data = d;
		tick;
		wr16_en = 0;
	endtask : w16
	task automatic t_reset;
		cmp16(stack_top_pointer_r, 16'h10FF);
		cpu.xfer(0, 0, 16'h005D, 8'h00, q, h);
		cmp8(q, 8'hFF);
		cpu.xfer(0, 0, 16'h005E, 8'h00, q, h);
		cmp8(q, 8'h10);
	endtask : t_reset
	task automatic t_regs;
		tick;
		wr_en = 1;
		wr_addr = 5'h05;
		wr_data = 8'hAA;
		rd_a_addr = 5'h05;
		tick;
		wr_en = 0;
		cmp8(rd_a_data_r, 8'hAA);
		w16(5'h1B, 16'h1234);
		rd_a_addr = 5'h1A;
		rd_b_addr = 5'h1B;
		tick;
		cmp16(rd_w_data_r, 16'h1234);
		cmp8(rd_a_data_r, 8'h34);
		cmp8(rd_b_data_r, 8'h12);
		cpu.xfer(0, 0, 16'h0005, 8'h00, q, h);
		cmp8(q, 8'hAA);
		cmp8({7'h00, h}, 8'h01);
		// Data-space store into a working register, read back on operand port B
		cpu.xfer(0, 1, 16'h0007, 8'hC3, q, h);
		rd_b_addr = 5'h07;
		tick;
		cmp8(rd_b_data_r, 8'hC3);
	endtask : t_regs
	// Post-increment, pre-decrement and displacement, each landing on register 5
	task automatic t_ptr;
		logic [4:0] pa[3] = '{5'h1A, 5'h1C, 5'h1E};
		logic [15:0] ini[3] = '{16'h0005, 16'h0006, 16'h0001};
		logic [15:0] code[3] = '{16'h0004, 16'h0009, 16'h004E};
		logic [15:0] fin[3] = '{16'h0006, 16'h0005, 16'h0001};
		for (int i = 0; i < 3; i++) begin
			w16(pa[i], ini[i]);
			cpu.xfer(2, 0, code[i], 8'h00, q, h);
			cmp8(q, 8'hAA);
			cmp16(ptr_addr_r, 16'h0005);
			rd_a_addr = pa[i];
			tick;
			cmp16(rd_w_data_r, fin[i]);
		end
		// Code 3 selects the last pair; plain mode writes register 1 and leaves the pair alone
		cpu.xfer(2, 1, 16'h0003, 8'h5A, q, h);
		cmp16(ptr_addr_r, 16'h0001);
		cpu.xfer(0, 0, 16'h0001, 8'h00, q, h);
		cmp8(q, 8'h5A);
		rd_a_addr = 5'h1E;
		tick;
		cmp16(rd_w_data_r, 16'h0001);
	endtask : t_ptr
	task automatic t_sp16;
		// Each pair runs with nothing else touching the temporary byte in between
		cpu.xfer(1, 1, 16'h003D, 8'h34, q, h);
		cmp16(stack_top_pointer_r, 16'h10FF);
		cpu.xfer(0, 1, 16'h005E, 8'h12, q, h);
		cmp16(stack_top_pointer_r, 16'h1234);
		cpu.xfer(1, 0, 16'h003D, 8'h00, q, h);
		cmp8(q, 8'h34);
		cpu.xfer(0, 0, 16'h005E, 8'h00, q, h);
		cmp8(q, 8'h12);
		cpu.xfer(0, 1, 16'h005C, 8'h77, q, h);
		cpu.xfer(1, 0, 16'h003C, 8'h00, q, h);
		cmp8(q, 8'h77);
		cmp8({7'h00, h}, 8'h01);
		cpu.xfer(1, 0, 16'h003E, 8'h00, q, h);
		cmp8(q, 8'h77);
		cpu.xfer(0, 0, 16'h0060, 8'h00, q, h);
		cmp8({7'h00, h}, 8'h00);
	endtask : t_sp16
	// Byte push and pop, call and return, from a known pointer
	task automatic t_stack;
		rfsp_pkg::rfsp_stk_e ops[4] = '{rfsp_pkg::STK_PUSH, rfsp_pkg::STK_POP, rfsp_pkg::STK_CALL, rfsp_pkg::STK_RET};
		logic [15:0] d[4] = '{16'hFFFF, 16'h0001, 16'hFFFE, 16'h0002};
		logic [15:0] e = 16'h1234;
		for (int i = 0; i < 4; i++) begin
			tick;
			stk_op = ops[i];
			tick;
			stk_op = rfsp_pkg::STK_NONE;
			e = e + d[i];
			cmp16(stack_top_pointer_r, e);
		end
	endtask : t_stack
	// Reset again in mid-run, with the stack pointer moved away from its reset value
	task automatic t_rst2;
		tick;
		reset = 1'b1;
		repeat (2) tick;
		reset = 1'b0;
		cmp16(stack_top_pointer_r, 16'h10FF);
		cpu.xfer(0, 0, 16'h005D, 8'h00, q, h);
		cmp8(q, 8'hFF);
	endtask : t_rst2
	// Hang guard
	initial begin
		#20000;
		bad_count++;
		results;
	end
	initial begin
		reset = 1;
		{wr_en, wr16_en, wr_addr, rd_a_addr, rd_b_addr, wr_data, wr16_data} = '0;
		stk_op = rfsp_pkg::STK_NONE;
		bad_count = 0;
		compares = 0;
		repeat (4) @(posedge sys_clk);
		#1 reset = 0;
		t_reset;
		t_regs;
		t_ptr;
		t_sp16;
		t_stack;
		t_rst2;
		results;
	end
endmodule : tb_rfsp_regfile
